// *** logic/scc_strap_map.vh ***
`ifndef SCC_STRAP_MAP_VH
`define SCC_STRAP_MAP_VH
// register byte addresses (word aligned)
`define SCC_ADDR_WORD 8'h00
`define SCC_ADDR_GSTAT 8'h04
`define SCC_ADDR_MEMBUS 8'h08
`define SCC_ADDR_PANEL 8'h0C
`define SCC_ADDR_VOLT 8'h10
`define SCC_ADDR_LIF1 8'h14
`define SCC_ADDR_LIF0 8'h18
`define SCC_ADDR_WAKE 8'h1C
`define SCC_ADDR_STAT 8'h20
// configuration word bit positions
`define SCC_CNF_ROM 0
`define SCC_CNF_BUSA 2
`define SCC_CNF_GP_LO 4
`define SCC_CNF_GP_HI 7
`define SCC_CNF_GP11 8
`define SCC_CNF_WAKE 9
`define SCC_CNF_VOLT 11
`define SCC_CNF_MMA 13
`define SCC_CNF_MMB 14
`define SCC_CNF_WIDTH 15
`define SCC_CNF_MMC 16
`define SCC_CNF_BUSB 17
`define SCC_CNF_PNL0 18
`define SCC_CNF_PNL1 19
`define SCC_CNF_CLK 20
`define SCC_CNF_LIFL_LO 22
`define SCC_CNF_LIFL_HI 27
`define SCC_CNF_LIFH_LO 28
`define SCC_CNF_LIFH_HI 31
// starred bits capture a pulldown as one
`define SCC_INVERT_MASK 32'h0000_0141
// bus a lines that swap places on their way into the word
`define SCC_PIN_GP11 11
`define SCC_PIN_VOLT 8
// register field positions
`define SCC_GS_GP_LO 4
`define SCC_GS_GP_HI 7
`define SCC_GS_GP11 3
`define SCC_MB_BUSB 4
`define SCC_MB_MMA 5
`define SCC_MB_MMB 6
`define SCC_MB_MMC 7
`define SCC_VC_AUTO 5
`define SCC_VC_VAL_HI 4
`define SCC_LIF0_LO 4
`define SCC_LIF0_HI 7
`define SCC_LIF1_HI 5
// voltage field reset encoding meaning five volts
`define SCC_VOLT_5V 5'h00
`endif

// *** logic/scc_strap_capture.v ***
`timescale 1ns/100ps
`default_nettype none
`include "scc_strap_map.vh"
module scc_strap_capture (
	// clock and reset
	input wire clock,
	input wire rst_b,
	// raw memory data bus levels, low = pulldown
	input wire [15:0] memBusA,
	input wire [15:0] memBusB,
	// captured configuration word
	output reg [31:0] strapConfigWord
);
	wire [31:0] rawWord;
	wire [31:0] invertMask;
	reg capturing_reg;
	genvar i;
	// line 11 lands in bit 8 and line 8 in bit 11, the rest in place
	assign rawWord = {memBusB, memBusA[15:12], memBusA[`SCC_PIN_VOLT],
		memBusA[10:9], memBusA[`SCC_PIN_GP11], memBusA[7:0]};
	assign invertMask = `SCC_INVERT_MASK;
	// inverted bits and sampling during reset
	generate
		for (i = 0; i < 32; i = i + 1)
		begin : gBit
			always @(posedge clock)
			begin
				if (!rst_b || capturing_reg)
					strapConfigWord[i] <= rawWord[i] ^ invertMask[i];
			end
		end
	endgenerate
	// one more sample on the first edge after release, then frozen
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			capturing_reg <= 1'b1;
		else
			capturing_reg <= 1'b0;
	end
endmodule // scc_strap_capture
`default_nettype wire

// *** logic/scc_strap_config.v ***
// Overview of operation
// - strap lines 7..4 and 11 read back as general status bits 7..4, 3
// - voltage strap pulled down forces detectors to voltage field bits 4..0
// - forced voltage field resets to the five volt encoding
// - voltage strap open leaves detectors on automatic detect
// - wake strap pulled down: video enabled by writing one to port bit 0
// - wake strap open: video enabled through setup ports x102h and 46E8h
// - three memory mode straps appear in memory/bus register bits 5,6,7
// - bus architecture from two straps; second shows read-only at bit 4
// - host width strap pulled down selects 16-bit, else 32-bit path
// - clock strap pulled down selects 2x local clock, else 1x
// - two panel straps load panel select bits 0 and 1
// - six straps load local if reg1 bits 5..0, four load reg0 bits 7..4
// - starred straps capture pulldown as one, all others as zero
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "scc_strap_map.vh"
module scc_strap_config (
	// clock and reset
	input wire clock,
	input wire rst_b,
	// strap pins
	input wire [15:0] memBusA,
	input wire [15:0] memBusB,
	// ahb-lite slave
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// device controls
	output wire [1:0] busArchSel,
	output wire hostWidth16,
	output wire localClk2x,
	output wire [2:0] memoryModeSel,
	output wire [1:0] panelTypeSel,
	output wire romMappedOut,
	output wire voltForce,
	output wire [4:0] voltDetectValue,
	output wire wakeupPortSel3c3,
	output wire videoEnable,
	// local bus interface defaults
	output wire [7:0] localIfReg0,
	output wire [7:0] localIfReg1
);
	wire [31:0] strap_config_word;
	reg [1:0] memModeRw_reg;
	reg [1:0] panelSel_reg;
	reg [5:0] volt_reg;
	reg [5:0] lif1_reg;
	reg [3:0] lif0_reg;
	reg wake3c3_reg;
	reg wakeSetup_reg;
	reg loadPending_reg;
	reg wrPend_reg;
	reg [7:0] wrAddr_reg;
	reg [31:0] rdNext;
	wire addrPhase;

	scc_strap_capture uCapture (
		.clock(clock),
		.rst_b(rst_b),
		.memBusA(memBusA),
		.memBusB(memBusB),
		.strapConfigWord(strap_config_word)
	);

	assign addrPhase = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// bus writes land one cycle after the address phase
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
		end
		else
		begin
			wrPend_reg <= addrPhase && hwrite;
			if (addrPhase)
				wrAddr_reg <= haddr;
		end
	end

	// strap defaults are loaded at the first edge after release, the same edge that takes the word's last sample
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			loadPending_reg <= 1'b1;
		else
			loadPending_reg <= 1'b0;
	end

	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			memModeRw_reg <= 2'h0;
			panelSel_reg <= 2'h0;
			volt_reg <= {1'b0, `SCC_VOLT_5V};
			lif1_reg <= 6'h00;
			lif0_reg <= 4'h0;
			wake3c3_reg <= 1'b0;
			wakeSetup_reg <= 1'b0;
		end
		else if (loadPending_reg)
		begin
			memModeRw_reg <= {strap_config_word[`SCC_CNF_MMB], strap_config_word[`SCC_CNF_MMA]};
			panelSel_reg <= {strap_config_word[`SCC_CNF_PNL1], strap_config_word[`SCC_CNF_PNL0]};
			lif1_reg <= strap_config_word[`SCC_CNF_LIFL_HI:`SCC_CNF_LIFL_LO];
			lif0_reg <= strap_config_word[`SCC_CNF_LIFH_HI:`SCC_CNF_LIFH_LO];
		end
		else if (wrPend_reg)
		begin
			case (wrAddr_reg)
				`SCC_ADDR_MEMBUS:
					memModeRw_reg <= hwdata[`SCC_MB_MMB:`SCC_MB_MMA];
				`SCC_ADDR_PANEL:
					panelSel_reg <= hwdata[1:0];
				`SCC_ADDR_VOLT:
					volt_reg <= hwdata[`SCC_VC_AUTO:0];
				`SCC_ADDR_LIF1:
					lif1_reg <= hwdata[`SCC_LIF1_HI:0];
				`SCC_ADDR_LIF0:
					lif0_reg <= hwdata[`SCC_LIF0_HI:`SCC_LIF0_LO];
				`SCC_ADDR_WAKE:
				begin
					// bit 0: 3C3h-style enable, bit 1: setup-port enable
					wake3c3_reg <= hwdata[0];
					wakeSetup_reg <= hwdata[1];
				end
				default:
					wake3c3_reg <= wake3c3_reg;
			endcase
		end
	end

	// strap low (cnf bit 0) means pulldown for non-starred bits
	assign voltForce = ~strap_config_word[`SCC_CNF_VOLT];
	// when forced the register's bit 5 is ignored
	assign voltDetectValue = volt_reg[`SCC_VC_VAL_HI:0];
	assign wakeupPortSel3c3 = ~strap_config_word[`SCC_CNF_WAKE];
	// only the enable path chosen by the strap can wake the video
	assign videoEnable = wakeupPortSel3c3 ? wake3c3_reg
		: wakeSetup_reg;
	assign busArchSel = {strap_config_word[`SCC_CNF_BUSB], strap_config_word[`SCC_CNF_BUSA]};
	assign hostWidth16 = ~strap_config_word[`SCC_CNF_WIDTH];
	assign localClk2x = ~strap_config_word[`SCC_CNF_CLK];
	assign memoryModeSel = {strap_config_word[`SCC_CNF_MMC], memModeRw_reg};
	assign panelTypeSel = panelSel_reg;
	assign romMappedOut = strap_config_word[`SCC_CNF_ROM];
	assign localIfReg1 = {2'h0, lif1_reg};
	assign localIfReg0 = {lif0_reg, 4'h0};

	always @*
	begin
		rdNext = 32'h0000_0000;
		case (haddr)
			`SCC_ADDR_WORD:
				rdNext = strap_config_word;
			`SCC_ADDR_GSTAT:
			begin
				rdNext[`SCC_GS_GP_HI:`SCC_GS_GP_LO] =
					strap_config_word[`SCC_CNF_GP_HI:`SCC_CNF_GP_LO];
				rdNext[`SCC_GS_GP11] = strap_config_word[`SCC_CNF_GP11];
			end
			`SCC_ADDR_MEMBUS:
			begin
				rdNext[`SCC_MB_BUSB] = strap_config_word[`SCC_CNF_BUSB];
				rdNext[`SCC_MB_MMB:`SCC_MB_MMA] = memModeRw_reg;
				rdNext[`SCC_MB_MMC] = strap_config_word[`SCC_CNF_MMC];
			end
			`SCC_ADDR_PANEL:
				rdNext[1:0] = panelSel_reg;
			`SCC_ADDR_VOLT:
				rdNext[`SCC_VC_AUTO:0] = volt_reg;
			`SCC_ADDR_LIF1:
				rdNext[7:0] = localIfReg1;
			`SCC_ADDR_LIF0:
				rdNext[7:0] = localIfReg0;
			`SCC_ADDR_WAKE:
				rdNext[1:0] = {wakeSetup_reg, wake3c3_reg};
			`SCC_ADDR_STAT:
				rdNext[4:0] = {videoEnable, voltForce, localClk2x,
					hostWidth16, wakeupPortSel3c3};
			default:
				rdNext = 32'h0000_0000;
		endcase
	end

	// read data registered so it stands in the data phase
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			hrdata <= 32'h0000_0000;
		else if (addrPhase && !hwrite)
			hrdata <= rdNext;
	end
endmodule // scc_strap_config
`default_nettype wire

// *** tb/scc_strap_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module scc_strap_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// strap lines and captured controls
	input wire logic [15:0] memBusA,
	input wire logic [15:0] memBusB,
	input wire logic [1:0] busArchSel,
	input wire logic hostWidth16,
	input wire logic localClk2x,
	input wire logic voltForce,
	input wire logic wakeupPortSel3c3,
	input wire logic romMappedOut
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// two edges past release the capture flops have closed for good
	sequence settled;
		$past(rst_b) && $past(rst_b, 2);
	endsequence
	sequence released;
		$rose(rst_b);
	endsequence
	a_held_width: assert property (settled |->
		$stable(hostWidth16))
		else $error("host width moved after reset");
	a_held_clock: assert property (settled |->
		$stable(localClk2x))
		else $error("clock ratio moved after reset");
	a_held_bus: assert property (settled |->
		$stable(busArchSel))
		else $error("bus architecture moved after reset");
	a_held_volt: assert property (settled |->
		$stable(voltForce))
		else $error("voltage force moved after reset");
	a_held_wake: assert property (settled |->
		$stable(wakeupPortSel3c3))
		else $error("wake port select moved after reset");
	a_width_capture: assert property (released |->
		hostWidth16 == !$past(memBusA[15]))
		else $error("host width not captured");
	a_clock_capture: assert property (released |->
		localClk2x == !$past(memBusB[4]))
		else $error("clock ratio not captured");
	a_volt_capture: assert property (released |->
		voltForce == !$past(memBusA[8]))
		else $error("voltage force not captured");
	a_wake_capture: assert property (released |->
		wakeupPortSel3c3 == !$past(memBusA[9]))
		else $error("wake port select not captured");
	a_rom_capture: assert property (released |->
		romMappedOut == !$past(memBusA[0]))
		else $error("rom mapping not captured");
endmodule // scc_strap_checker
bind scc_strap_config scc_strap_checker u_check (.clock(clock),
	.rst_b(rst_b), .memBusA(memBusA), .memBusB(memBusB),
	.busArchSel(busArchSel), .hostWidth16(hostWidth16),
	.localClk2x(localClk2x), .voltForce(voltForce),
	.wakeupPortSel3c3(wakeupPortSel3c3), .romMappedOut(romMappedOut));
`default_nettype wire

// *** tb/scc_strap_board.sv ***
`timescale 1ns/100ps
`default_nettype none
module scc_strap_board (
	// fitted pulldowns, one bit per line
	input wire logic [15:0] pullDownA,
	input wire logic [15:0] pullDownB,
	// levels on the memory data lines
	output wire logic [15:0] memBusA,
	output wire logic [15:0] memBusB
);
	// unfitted lines sit high on their keepers, so only a pulldown reads low
	assign memBusA = ~pullDownA;
	assign memBusB = ~pullDownB;
endmodule // scc_strap_board
`default_nettype wire

// *** tb/scc_strap_config_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module scc_strap_config_test;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b1;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] haddr = 8'h00;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [15:0] pullDownA = 16'h0;
	logic [15:0] pullDownB = 16'h0;
	int fail_count = 0;
	int checked = 0;
	wire logic [15:0] memBusA, memBusB;
	wire logic hreadyout, hresp, hostWidth16, localClk2x, romMappedOut;
	wire logic voltForce, wakeupPortSel3c3, videoEnable;
	wire logic [1:0] busArchSel, panelTypeSel;
	wire logic [2:0] memoryModeSel;
	wire logic [4:0] voltDetectValue;
	wire logic [7:0] localIfReg0, localIfReg1;
	wire logic [31:0] hrdata;
	wire logic hready = hreadyout;
	scc_strap_board u_board (.pullDownA(pullDownA), .pullDownB(pullDownB),
		.memBusA(memBusA), .memBusB(memBusB));
	scc_strap_config u_dut (.clock(clock), .rst_b(rst_b), .memBusA(memBusA),
		.memBusB(memBusB), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.busArchSel(busArchSel), .hostWidth16(hostWidth16),
		.localClk2x(localClk2x), .memoryModeSel(memoryModeSel),
		.panelTypeSel(panelTypeSel), .romMappedOut(romMappedOut),
		.voltForce(voltForce), .voltDetectValue(voltDetectValue),
		.wakeupPortSel3c3(wakeupPortSel3c3), .videoEnable(videoEnable),
		.localIfReg0(localIfReg0), .localIfReg1(localIfReg1));
	initial
	begin
		forever #10 clock = ~clock;
	end
	task automatic close_out;
		begin
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
		end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
		end
	endtask
	// one single word transfer; a hung bus ends the run
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		begin
		n = 0;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock); while (hready !== 1'b1 && ++n < 20);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1 && ++n < 40);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
		if (n >= 20)
		begin
			fail_count++;
			close_out;
		end
		end
	endtask
	task automatic boot(input logic [15:0] pa, input logic [15:0] pb);
		begin
		pullDownA <= pa;
		pullDownB <= pb;
		rst_b <= 1'b0;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
		end
	endtask
	// straps flip after reset, so every strap-derived result also proves the hold
	task automatic capture_case(input logic [15:0] pa, input logic [15:0] pb);
		logic [31:0] e;
		begin
		boot(pa, pb);
		e = {~pb, ~pa[15:12], ~pa[8], ~pa[10], ~pa[9], ~pa[11], ~pa[7:0]};
		e = e ^ 32'h0000_0141;
		pullDownA <= ~pa;
		pullDownB <= ~pb;
		xfer(8'h00, 1'b0, 32'h0);
		chk(rd, e);
		xfer(8'h04, 1'b0, 32'h0);
		chk(rd, {e[7:4], e[8], 3'h0});
		chk({hostWidth16, localClk2x}, {pa[15], pb[4]});
		chk({voltForce, wakeupPortSel3c3}, {pa[8], pa[9]});
		chk(romMappedOut, pa[0]);
		chk(panelTypeSel, {~pb[3:2]});
		chk(memoryModeSel, {~pb[0], ~pa[14:13]});
		chk(busArchSel, {~pb[1], ~pa[2]});
		chk(voltDetectValue, 5'h00);
		chk(localIfReg1, {2'h0, ~pb[11:6]});
		chk(localIfReg0, {~pb[15:12], 4'h0});
		end
	endtask
	task automatic reg_case(input logic [15:0] pa);
		begin
		boot(pa, 16'h0003);
		xfer(8'h0C, 1'b1, 32'h2);
		xfer(8'h0C, 1'b0, 32'h0);
		chk({rd[7:0], panelTypeSel}, {8'h02, 2'h2});
		xfer(8'h08, 1'b1, 32'hFFFF_FFFF);
		xfer(8'h08, 1'b0, 32'h0);
		chk({rd[7:0], memoryModeSel}, {8'h60, 3'h3});
		xfer(8'h10, 1'b1, 32'h1F);
		xfer(8'h10, 1'b0, 32'h0);
		chk({rd[7:0], voltDetectValue, voltForce}, {8'h1F, 5'h1F, pa[8]});
		xfer(8'h1C, 1'b1, 32'h1);
		xfer(8'h40, 1'b0, 32'h0);
		chk(rd, 32'h0);
		chk(videoEnable, pa[9]);
		xfer(8'h1C, 1'b1, 32'h2);
		xfer(8'h00, 1'b1, 32'h0);
		xfer(8'h00, 1'b0, 32'h0);
		chk({rd[31:16], videoEnable}, {16'hFFFC, !pa[9]});
		end
	endtask
	initial
	begin
		capture_case(16'h0000, 16'h0000);
		capture_case(16'hFFFF, 16'hFFFF);
		capture_case(16'hA5C3, 16'h3C5A);
		reg_case(16'h0300);
		reg_case(16'h0000);
		close_out;
	end
endmodule // scc_strap_config_test
`default_nettype wire
